// *** src/gfr_pkg.sv ***
// Shared constants of the rate-sensor queue readout and configuration registers.
package gfr_pkg;
	// Register byte addresses on the serial register port.
	localparam logic [7:0] ADDR_ERR     = 8'h02;
	localparam logic [7:0] ADDR_DATA_LO = 8'h12;
	localparam logic [7:0] ADDR_DATA_HI = 8'h17;
	localparam logic [7:0] ADDR_STATUS  = 8'h1B;
	localparam logic [7:0] ADDR_FILL0   = 8'h22;
	localparam logic [7:0] ADDR_FILL1   = 8'h23;
	localparam logic [7:0] ADDR_QPORT   = 8'h24;
	localparam logic [7:0] ADDR_RFCFG   = 8'h42;
	localparam logic [7:0] ADDR_RANGE   = 8'h43;
	localparam logic [7:0] ADDR_QCFG0   = 8'h46;
	localparam logic [7:0] ADDR_QCFG1   = 8'h47;
	localparam logic [7:0] ADDR_CMD     = 8'h7E;
	// Command code that empties the queue.
	localparam logic [7:0] CMD_QFLUSH   = 8'hB0;
	// Reset values.
	localparam logic [6:0] RFCFG_RST    = 7'h28;
	localparam logic [2:0] RANGE_RST    = 3'h0;
	localparam logic [7:0] QCFG0_RST    = 8'h80;
	localparam logic [7:0] QCFG1_RST    = 8'h10;
	// Field positions.
	localparam int         QCFG_HDR_BIT = 4;
	localparam int         DRDY_BIT     = 6;
	localparam int         ODR_LSB      = 0;
	localparam int         BWP_LSB      = 4;
	// Legal code limits and the error code for a bad rate/filter pair.
	localparam logic [3:0] ODR_MIN      = 4'h6;
	localparam logic [3:0] ODR_MAX      = 4'hD;
	localparam logic [2:0] BWP_MAX      = 3'h2;
	localparam logic [2:0] RANGE_MAX    = 3'h4;
	localparam logic [3:0] ERR_CFG      = 4'h6;
	localparam logic [15:0] SENS_X10    = 16'h00A4;
	// Byte returned when no frame is waiting.
	localparam logic [7:0] QEMPTY_BYTE  = 8'h00;
	// Sizes.
	localparam int         FILL_W       = 11;
	localparam int         FRAME_MAX    = 8;
	localparam int         QDEPTH       = 16;
	localparam int         QWORD_W      = 10;
	// Timing: clock rate and slowest legal output rate.
	localparam int         CLK_HZ       = 100_000_000;
	localparam int         ODR_SLOW_HZ  = 25;
	localparam int         SLOW_CYCLES  = CLK_HZ / ODR_SLOW_HZ;
endpackage

// *** src/gfr_q_if.sv ***
// Byte path between the register logic and its staging queue.
`timescale 1ns/1ps
interface gfr_q_if;
	logic                        wr_valid; // Producer offers a word.
	logic                        wr_ready; // Queue has room.
	logic [gfr_pkg::QWORD_W-1:0] wr_data;  // {last, header, byte}.
	logic                        rd_valid; // Queue holds a word.
	logic                        rd_ready; // Consumer takes it.
	logic [gfr_pkg::QWORD_W-1:0] rd_data;  // Oldest word.
	logic                        flush;    // Empties the queue.
	modport fifo (input wr_valid, wr_data, rd_ready, flush,
		output wr_ready, rd_valid, rd_data);
	modport ctl (output wr_valid, wr_data, rd_ready, flush,
		input wr_ready, rd_valid, rd_data);
endinterface

// *** src/gfr_fifo.sv ***
// Small show-ahead queue with flush, valid and ready on both sides.
`timescale 1ns/1ps
module gfr_fifo #(
	parameter int W = 10,
	parameter int D = 16
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	gfr_q_if.fifo     q
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];  // Storage.
	logic [AW-1:0] wp;       // Write index.
	logic [AW-1:0] rp;       // Read index.
	logic [AW:0]   cnt;      // Words held.
	logic          rdy;      // Registered room flag.
	wire           push = q.wr_valid & rdy;
	wire           pop  = q.rd_valid & q.rd_ready;
	wire  [AW:0]   next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
	assign q.wr_ready = rdy;
	assign q.rd_valid = (cnt != '0);
	assign q.rd_data  = mem[rp];
	// Storage is written without reset; only the indices, count and room flag need a value.
	always_ff @(posedge ref_clk_i) begin
		if (push)
			mem[wp] <= q.wr_data;
	end
	// Indices wrap naturally because the depth is a power of two.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || q.flush) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
			rdy <= 1'b1;
		end else begin
			wp  <= wp + AW'(push);
			rp  <= rp + AW'(pop);
			cnt <= next_cnt;
			rdy <= (next_cnt != (AW+1)'(D));
		end
	end
endmodule

// *** src/gfr_regs.sv ***
// Queue readout, rate/filter and full-scale registers of the rate sensor.
`timescale 1ns/1ps
module gfr_regs #(
	parameter int SAMPLE_PERIOD_SLOW = gfr_pkg::SLOW_CYCLES
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_rd_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_burst_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        q_wr_valid_i,
	input  wire logic [7:0]  q_wr_data_i,
	input  wire logic        q_wr_hdr_i,
	input  wire logic        q_wr_last_i,
	output logic             q_wr_ready_o,
	input  wire logic        q_frame_wr_i,
	input  wire logic        q_skip_i,
	input  wire logic [3:0]  q_frame_len_i,
	output logic             q_frame_rd_o,
	output logic             q_flush_o,
	output logic             hdr_en_o,
	input  wire logic        sample_rdy_i,
	output logic      [3:0]  odr_code_o,
	output logic      [2:0]  bwp_code_o,
	output logic             cfg_illegal_o,
	output logic             sample_tick_o,
	output logic      [2:0]  range_code_o,
	output logic      [15:0] sens_x10_o
);
	// Reset copies of the two rate/filter fields for the registered outputs.
	localparam logic [3:0] RFCFG_ODR_RST = gfr_pkg::RFCFG_RST[3:0];
	localparam logic [2:0] RFCFG_BWP_RST = gfr_pkg::RFCFG_RST[6:4];

	// Frame buffer states: gathering a frame, or handing it to the host.
	typedef enum logic [1:0] {
		ST_LOAD  = 2'b01,
		ST_SERVE = 2'b10
	} gfr_state_t;

	gfr_q_if qi ();

	// Configuration and status registers.
	logic [6:0]  rfcfg;   // Rate code and bandwidth code.
	logic [2:0]  range;   // Full-scale code.
	logic [7:0]  qcfg0;   // Queue threshold byte, stored only.
	logic [7:0]  qcfg1;   // Queue format flags.
	logic [3:0]  err;     // Error code.
	logic        drdy;    // Sample-ready flag.

	// Fill bookkeeping.
	logic [gfr_pkg::FILL_W-1:0] fill;    // Byte count seen by the host.
	logic [gfr_pkg::FILL_W-1:0] frames;  // Complete frames stored.

	// Frame buffer and its pointers.
	gfr_state_t  state;
	logic [7:0]  fb [gfr_pkg::FRAME_MAX];
	logic [3:0]  fb_len;  // Bytes held in the current frame.
	logic [3:0]  wcnt;    // Bytes gathered so far.
	logic [3:0]  rptr;    // Next byte the host gets.

	// Burst address tracking.
	logic        burst_q;    // A burst has already read once.
	logic [7:0]  brst_addr;  // Address for the next burst read.

	// Output-rate tick counter.
	logic [22:0] tcnt;

	// Burst reads after the first use the tracked address.
	wire [7:0] eff_addr = burst_q ? brst_addr : reg_addr_i;
	wire       qport_hit = (eff_addr == gfr_pkg::ADDR_QPORT);
	wire       burst_end = burst_q & ~reg_burst_i;
	wire       serving   = (state == ST_SERVE);
	// Only burst reads move the frame pointer; a lone read is repeated later.
	wire       qport_rd  = reg_rd_i & reg_burst_i & qport_hit & serving;
	wire       last_byte = (rptr == fb_len - 4'h1);
	wire       frame_done = qport_rd & last_byte;

	// Write decodes.
	wire       wr_rfcfg = reg_wr_i & (reg_addr_i == gfr_pkg::ADDR_RFCFG);
	wire       wr_range = reg_wr_i & (reg_addr_i == gfr_pkg::ADDR_RANGE);
	wire       wr_qcfg0 = reg_wr_i & (reg_addr_i == gfr_pkg::ADDR_QCFG0);
	wire       wr_qcfg1 = reg_wr_i & (reg_addr_i == gfr_pkg::ADDR_QCFG1);
	wire       flush    = reg_wr_i & (reg_addr_i == gfr_pkg::ADDR_CMD)
		& (reg_wdata_i == gfr_pkg::CMD_QFLUSH);

	// Any read inside the rate data window clears the ready flag.
	wire       data_rd = reg_rd_i & (eff_addr >= gfr_pkg::ADDR_DATA_LO)
		& (eff_addr <= gfr_pkg::ADDR_DATA_HI);

	// Field views of the rate/filter register.
	wire [3:0] odr = rfcfg[gfr_pkg::ODR_LSB +: 4];
	wire [2:0] bwp = rfcfg[gfr_pkg::BWP_LSB +: 3];
	wire       odr_bad = (odr < gfr_pkg::ODR_MIN) | (odr > gfr_pkg::ODR_MAX);
	wire       bwp_bad = (bwp > gfr_pkg::BWP_MAX);
	wire       illegal = odr_bad | bwp_bad;

	// Queue hookup: producer words go straight in.
	assign qi.wr_valid = q_wr_valid_i;
	assign qi.wr_data  = {q_wr_last_i, q_wr_hdr_i, q_wr_data_i};
	assign qi.rd_ready = (state == ST_LOAD);
	assign qi.flush    = flush;
	assign q_wr_ready_o = qi.wr_ready;

	// Unpacked queue word.
	wire       w_last = qi.rd_data[9];
	wire       w_hdr  = qi.rd_data[8];
	wire [7:0] w_byte = qi.rd_data[7:0];
	wire       pop    = qi.rd_valid & qi.rd_ready;
	// Header bytes are dropped when headers are turned off.
	wire       keep   = ~w_hdr | qcfg1[gfr_pkg::QCFG_HDR_BIT];
	wire [3:0] next_len = wcnt + {3'h0, keep};

	// Fill arithmetic: one frame or skip frame in, one frame out.
	wire       fill_in  = q_frame_wr_i | q_skip_i;
	wire [gfr_pkg::FILL_W-1:0] add_b =
		fill_in ? {7'h00, q_frame_len_i} : '0;
	wire [gfr_pkg::FILL_W-1:0] sub_b = frame_done ? {7'h00, fb_len} : '0;
	wire [gfr_pkg::FILL_W-1:0] sum_b = fill + add_b;
	wire [gfr_pkg::FILL_W-1:0] next_fill = (sum_b < sub_b) ? '0 : sum_b - sub_b;
	wire       all_read = frame_done & (frames == 11'h001) & ~q_frame_wr_i;

	// Output-rate period: the slowest period halved once per code step.
	wire [31:0] per_full = 32'(SAMPLE_PERIOD_SLOW) >> (odr - gfr_pkg::ODR_MIN);
	wire [22:0] period   = per_full[22:0];

	// Read multiplexer; unused bits read as zero.
	wire [7:0] qbyte = serving ? fb[rptr[2:0]] : gfr_pkg::QEMPTY_BYTE;
	wire [7:0] rd_val =
		(eff_addr == gfr_pkg::ADDR_ERR)    ? {4'h0, err} :
		(eff_addr == gfr_pkg::ADDR_STATUS) ? {1'b0, drdy, 6'h00} :
		(eff_addr == gfr_pkg::ADDR_FILL0)  ? fill[7:0] :
		(eff_addr == gfr_pkg::ADDR_FILL1)  ? {5'h00, fill[10:8]} :
		qport_hit                          ? qbyte :
		(eff_addr == gfr_pkg::ADDR_RFCFG)  ? {1'b0, rfcfg} :
		(eff_addr == gfr_pkg::ADDR_RANGE)  ? {5'h00, range} :
		(eff_addr == gfr_pkg::ADDR_QCFG0)  ? qcfg0 :
		(eff_addr == gfr_pkg::ADDR_QCFG1)  ? qcfg1 : 8'h00;

	// Staging queue between the producer and the frame buffer.
	gfr_fifo #(
		.W (gfr_pkg::QWORD_W),
		.D (gfr_pkg::QDEPTH)
	) u_fifo (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.q         (qi.fifo)
	);

	// Read data is captured on the strobe and held until the next read.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= rd_val;
	end

	// A burst that starts at the queue port stays there.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !reg_burst_i) begin
			burst_q   <= 1'b0;
			brst_addr <= 8'h00;
		end else if (reg_rd_i) begin
			burst_q   <= 1'b1;
			brst_addr <= qport_hit ? eff_addr : eff_addr + 8'h01;
		end
	end

	// Host-writable configuration; reserved bits are not stored.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rfcfg <= gfr_pkg::RFCFG_RST;
			range <= gfr_pkg::RANGE_RST;
			qcfg0 <= gfr_pkg::QCFG0_RST;
			qcfg1 <= gfr_pkg::QCFG1_RST;
		end else begin
			if (wr_rfcfg)
				rfcfg <= reg_wdata_i[6:0];
			if (wr_range)
				range <= reg_wdata_i[2:0];
			if (wr_qcfg0)
				qcfg0 <= reg_wdata_i;
			if (wr_qcfg1)
				qcfg1 <= reg_wdata_i & 8'h9F;
		end
	end

	// Error code follows the configuration one cycle later.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			err           <= 4'h0;
			cfg_illegal_o <= 1'b0;
		end else begin
			err           <= illegal ? gfr_pkg::ERR_CFG : 4'h0;
			cfg_illegal_o <= illegal;
		end
	end

	// Sample-ready flag; a new sample wins over a clearing read.
	// A range write is deliberately absent here so it never touches the flag.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			drdy <= 1'b0;
		else if (sample_rdy_i)
			drdy <= 1'b1;
		else if (data_rd)
			drdy <= 1'b0;
	end

	// Fill count and stored frame count move only on whole frames.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || flush) begin
			fill   <= '0;
			frames <= '0;
		end else begin
			fill   <= all_read ? '0 : next_fill;
			frames <= frames + {10'h000, q_frame_wr_i} - {10'h000, frame_done};
		end
	end

	// Frame buffer storage; only the byte of each kept word is stored, its last and header flags are dropped.
	always_ff @(posedge ref_clk_i) begin
		if (pop && keep && wcnt < 4'(gfr_pkg::FRAME_MAX))
			fb[wcnt[2:0]] <= w_byte;
	end

	// Frame sequencer: gather one frame, then serve it until fully read.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || flush) begin
			state  <= ST_LOAD;
			wcnt   <= 4'h0;
			fb_len <= 4'h0;
		end else begin
			unique case (state)
				ST_LOAD: begin
					if (pop && w_last) begin
						wcnt   <= 4'h0;
						fb_len <= next_len;
						if (next_len != 4'h0)
							state <= ST_SERVE;
					end else if (pop && keep) begin
						wcnt <= next_len;
					end
				end
				ST_SERVE: begin
					if (frame_done)
						state <= ST_LOAD;
				end
			endcase
		end
	end

	// Read pointer; an unfinished burst rewinds to the frame start.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || flush || frame_done)
			rptr <= 4'h0;
		else if (qport_rd)
			rptr <= rptr + 4'h1;
		else if (burst_end)
			rptr <= 4'h0;
	end

	// Event and configuration outputs.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			q_frame_rd_o <= 1'b0;
			q_flush_o    <= 1'b0;
			hdr_en_o     <= 1'b1;
			odr_code_o   <= RFCFG_ODR_RST;
			bwp_code_o   <= RFCFG_BWP_RST;
			range_code_o <= gfr_pkg::RANGE_RST;
			sens_x10_o   <= gfr_pkg::SENS_X10;
		end else begin
			q_frame_rd_o <= frame_done;
			q_flush_o    <= flush;
			hdr_en_o     <= qcfg1[gfr_pkg::QCFG_HDR_BIT];
			odr_code_o   <= odr;
			bwp_code_o   <= bwp;
			range_code_o <= range;
			// Reserved range codes give no sensitivity.
			sens_x10_o   <= (range <= gfr_pkg::RANGE_MAX) ?
				gfr_pkg::SENS_X10 << range : 16'h0000;
		end
	end

	// Sample tick at the chosen rate, one pulse every period cycles;
	// illegal codes stop it and hold the counter at zero.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || illegal) begin
			tcnt          <= 23'h000000;
			sample_tick_o <= 1'b0;
		end else if (tcnt >= period - 23'h000001) begin
			tcnt          <= 23'h000000;
			sample_tick_o <= 1'b1;
		end else begin
			tcnt          <= tcnt + 23'h000001;
			sample_tick_o <= 1'b0;
		end
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	fill_flush_a: assert property (q_flush_o |-> fill == '0)
		else $error("fill count not cleared by flush");
	fill_hold_a: assert property (!(fill_in || frame_done || flush) |=> $stable(fill))
		else $error("fill count moved off a frame boundary");
	fill_drain_a: assert property (all_read && !flush |=> fill == '0 && frames == '0)
		else $error("fill count not zero after last frame read");
	port_fixed_a: assert property (reg_rd_i && reg_burst_i && qport_hit
		|=> burst_q && brst_addr == gfr_pkg::ADDR_QPORT)
		else $error("burst address left the queue port");
	frame_rewind_a: assert property (burst_end && !qport_rd && !flush
		|=> rptr == 4'h0)
		else $error("partial frame not rewound");
	frame_hold_a: assert property (serving && !frame_done && !flush
		|=> serving && $stable(fb_len))
		else $error("frame advanced before full read");
	odr_bad_a: assert property (odr_bad |=> cfg_illegal_o && err == gfr_pkg::ERR_CFG)
		else $error("illegal rate code not flagged");
	drdy_clear_a: assert property (data_rd && !sample_rdy_i |=> !drdy)
		else $error("data read left sample-ready set");
	range_drdy_a: assert property (wr_range && !data_rd && !sample_rdy_i
		|=> $stable(drdy))
		else $error("range write changed sample-ready");
	sens_step_a: assert property ((range == 3'h1) [*2]
		|-> sens_x10_o == 16'h0148)
		else $error("sensitivity wrong for range code 1");
	done_pulse_a: assert property (frame_done |=> q_frame_rd_o ##1 !q_frame_rd_o)
		else $error("frame read event not a single pulse");

	frame_done_c: cover property (frame_done);
	rewind_c: cover property (burst_end && rptr != 4'h0);
	flush_c: cover property (flush && frames != '0);
	skip_c: cover property (q_skip_i && fill != '0);
endmodule

// *** verification/gfr_host_model.sv ***
// Host model that drives the serial register port of the rate sensor.
`timescale 1ns/1ps
module gfr_host_model (
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] rdata_i,
	output logic      [7:0] addr_o,
	output logic            rd_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o,
	output logic            burst_o
);
	// The port is quiet until a task runs.
	initial begin
		addr_o = 8'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
		burst_o = 1'b0;
	end

	// Single write: one strobe cycle, changed just after an edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i) #1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge ref_clk_i) #1;
		wr_o = 1'b0;
		// One more edge lets the registered copies of the new value settle.
		@(posedge ref_clk_i) #1;
	endtask

	// Single read: data is registered, so it is taken after the read edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i) #1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge ref_clk_i) #1;
		rd_o = 1'b0;
		d = rdata_i;
	endtask

	// Burst of n reads; the burst level falls only after the last byte.
	task automatic burst(input logic [7:0] a, input int n, output logic [7:0] d [8]);
		@(posedge ref_clk_i) #1;
		addr_o = a;
		burst_o = 1'b1;
		rd_o = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_i) #1;
			d[i] = rdata_i;
		end
		rd_o = 1'b0;
		burst_o = 1'b0;
	endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench of the queue readout and configuration registers.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
	localparam int SLOW = 256; // Short slow period keeps the rate sweep brief.
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic        reg_rd_i, reg_wr_i, reg_burst_i;
	logic        q_wr_valid_i = 1'b0;
	logic [7:0]  q_wr_data_i = 8'h00;
	logic        q_wr_hdr_i = 1'b0;
	logic        q_wr_last_i = 1'b0;
	logic        q_frame_wr_i = 1'b0;
	logic        q_skip_i = 1'b0;
	logic [3:0]  q_frame_len_i = 4'h0;
	logic        sample_rdy_i = 1'b0;
	logic        q_wr_ready_o, q_frame_rd_o, q_flush_o, hdr_en_o;
	logic [3:0]  odr_code_o;
	logic [2:0]  bwp_code_o, range_code_o;
	logic        cfg_illegal_o, sample_tick_o;
	logic [15:0] sens_x10_o;
	int          n_errors = 0;
	int          checked = 0;
	int          n_frd = 0, n_flush = 0, n_tick = 0, gap = 0, cnt = 0;
	int          exp_fill = 0; // Byte count the host should see.
	logic [7:0]  exp_q [$];    // Queued bytes, oldest first.
	logic [7:0]  rb, e;
	logic [7:0]  bb [8];
	logic [2:0]  bw;
	logic        ill;
	int          t;

	// Free-running clock of 10 ns.
	always #5 ref_clk_i = ~ref_clk_i;

	gfr_regs #(.SAMPLE_PERIOD_SLOW(SLOW)) DUT (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_burst_i(reg_burst_i), .reg_rdata_o(reg_rdata_o),
		.q_wr_valid_i(q_wr_valid_i), .q_wr_data_i(q_wr_data_i), .q_wr_hdr_i(q_wr_hdr_i),
		.q_wr_last_i(q_wr_last_i), .q_wr_ready_o(q_wr_ready_o),
		.q_frame_wr_i(q_frame_wr_i), .q_skip_i(q_skip_i), .q_frame_len_i(q_frame_len_i),
		.q_frame_rd_o(q_frame_rd_o), .q_flush_o(q_flush_o), .hdr_en_o(hdr_en_o),
		.sample_rdy_i(sample_rdy_i), .odr_code_o(odr_code_o), .bwp_code_o(bwp_code_o),
		.cfg_illegal_o(cfg_illegal_o), .sample_tick_o(sample_tick_o),
		.range_code_o(range_code_o), .sens_x10_o(sens_x10_o));

	gfr_host_model host (
		.ref_clk_i(ref_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .rd_o(reg_rd_i),
		.wr_o(reg_wr_i), .wdata_o(reg_wdata_i), .burst_o(reg_burst_i));

	// Pulse counters; the tick gap is the spacing of the last two ticks.
	always @(posedge ref_clk_i) begin
		if (q_frame_rd_o === 1'b1) n_frd++;
		if (q_flush_o === 1'b1) n_flush++;
		cnt++;
		if (sample_tick_o === 1'b1) begin
			n_tick++;
			gap = cnt;
			cnt = 0;
		end
	end

	// Reads both fill bytes; the upper five bits must stay zero.
	task automatic chk_fill(input int x);
		logic [7:0] lo, hi;
		host.rd(gfr_pkg::ADDR_FILL0, lo);
		host.rd(gfr_pkg::ADDR_FILL1, hi);
		`CHK("fill", 16'(x), {hi, lo})
	endtask

	// Pushes one four-byte frame, header first, waiting for room.
	task automatic push_frame();
		logic [7:0] b;
		for (int i = 0; i < 4; i++) begin
			b = 8'($urandom);
			@(posedge ref_clk_i) #1;
			q_wr_valid_i = 1'b1;
			q_wr_data_i = b;
			q_wr_hdr_i = (i == 0);
			q_wr_last_i = (i == 3);
			for (int k = 0; k < 50 && q_wr_ready_o !== 1'b1; k++) @(posedge ref_clk_i) #1;
			@(posedge ref_clk_i) #1;
			q_wr_valid_i = 1'b0;
			exp_q.push_back(b);
		end
	endtask

	// Reports a finished or a skipped frame of four bytes.
	task automatic frame_evt(input logic skip);
		@(posedge ref_clk_i) #1;
		q_frame_len_i = 4'h4;
		q_skip_i = skip;
		q_frame_wr_i = !skip;
		@(posedge ref_clk_i) #1;
		q_skip_i = 1'b0;
		q_frame_wr_i = 1'b0;
		exp_fill += 4;
	endtask

	// One-cycle new-sample pulse.
	task automatic new_sample();
		@(posedge ref_clk_i) #1;
		sample_rdy_i = 1'b1;
		@(posedge ref_clk_i) #1;
		sample_rdy_i = 1'b0;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 13000 cycles.
	initial begin
		#(50_000 * 10);
		n_errors++;
		stop_test();
	end

	// Main sequence.
	initial begin
		void'($urandom(32'h6802f885));
		repeat (20) @(posedge ref_clk_i);
		#1 rst_i = 1'b0;
		// Reset values and refused accesses.
		host.rd(gfr_pkg::ADDR_RFCFG, rb);
		`CHK("rate cfg", 8'h28, rb)
		`CHK("odr out", 4'h8, odr_code_o)
		host.rd(gfr_pkg::ADDR_RANGE, rb);
		`CHK("range", 8'h00, rb)
		chk_fill(0);
		host.rd(gfr_pkg::ADDR_QPORT, rb);
		`CHK("empty port", gfr_pkg::QEMPTY_BYTE, rb)
		host.wr(gfr_pkg::ADDR_FILL0, 8'hFF);
		chk_fill(0);
		host.rd(8'h30, rb);
		`CHK("unmapped", 8'h00, rb)
		`CHK("hdr en", 1'b1, hdr_en_o)
		$display("test reset done");
		// Every range code, with reserved bits set; the ready flag must survive.
		new_sample();
		for (int c = 0; c < 8; c++) begin
			host.wr(gfr_pkg::ADDR_RANGE, {5'h1F, 3'(c)});
			`CHK("range out", 3'(c), range_code_o)
			`CHK("sens", (c <= 4) ? 16'h00A4 << c : 16'h0000, sens_x10_o)
			host.rd(gfr_pkg::ADDR_RANGE, rb);
			`CHK("range rd", {5'h00, 3'(c)}, rb)
			host.rd(gfr_pkg::ADDR_STATUS, rb);
			`CHK("ready kept", 1'b1, rb[gfr_pkg::DRDY_BIT])
		end
		host.rd(8'(gfr_pkg::ADDR_DATA_LO + $urandom_range(0, 5)), rb);
		host.rd(gfr_pkg::ADDR_STATUS, rb);
		`CHK("ready clr", 1'b0, rb[gfr_pkg::DRDY_BIT])
		$display("test range done");
		// Every rate code with a random bandwidth; legal ones are timed.
		for (int c = 0; c < 16; c++) begin
			bw = 3'($urandom_range(0, 3));
			ill = (c < 6 || c > 13 || bw > 3'h2);
			host.wr(gfr_pkg::ADDR_RFCFG, {1'b0, bw, 4'(c)});
			`CHK("odr out", 4'(c), odr_code_o)
			`CHK("bwp out", bw, bwp_code_o)
			`CHK("illegal", ill, cfg_illegal_o)
			host.rd(gfr_pkg::ADDR_ERR, rb);
			`CHK("err code", {4'h0, ill ? gfr_pkg::ERR_CFG : 4'h0}, rb)
			t = n_tick;
			repeat (3 * SLOW + 8) @(posedge ref_clk_i);
			if (ill) begin
				`CHK("no ticks", t, n_tick)
			end else begin
				`CHK("tick gap", SLOW >> (c - 6), gap)
			end
		end
		host.wr(gfr_pkg::ADDR_RFCFG, 8'h28);
		$display("test rate done");
		// Frames: count only at the boundary, fill until refused, then a skip.
		push_frame();
		chk_fill(0);
		frame_evt(1'b0);
		chk_fill(4);
		while (q_wr_ready_o === 1'b1 && exp_q.size() < 32) begin
			push_frame();
			frame_evt(1'b0);
		end
		`CHK("refused", 1'b0, q_wr_ready_o)
		frame_evt(1'b1);
		chk_fill(exp_fill);
		// A partial burst must not advance and must be resent whole.
		t = n_frd;
		host.burst(gfr_pkg::ADDR_QPORT, 2, bb);
		`CHK("partial b0", exp_q[0], bb[0])
		`CHK("partial b1", exp_q[1], bb[1])
		repeat (2) @(posedge ref_clk_i);
		`CHK("no advance", t, n_frd)
		chk_fill(exp_fill);
		while (exp_q.size() > 0) begin
			repeat (8) @(posedge ref_clk_i);
			t = n_frd;
			host.burst(gfr_pkg::ADDR_QPORT, 4, bb);
			for (int i = 0; i < 4; i++) begin
				e = exp_q.pop_front();
				`CHK("queue byte", e, bb[i])
			end
			// Three edges so the pulse counter has moved before we look.
			repeat (3) @(posedge ref_clk_i);
			`CHK("frame read", t + 1, n_frd)
			exp_fill = (exp_q.size() > 0) ? exp_fill - 4 : 0;
			chk_fill(exp_fill);
		end
		$display("test drain done");
		// Flush clears the count and the port.
		push_frame();
		frame_evt(1'b0);
		host.wr(gfr_pkg::ADDR_CMD, gfr_pkg::CMD_QFLUSH);
		repeat (2) @(posedge ref_clk_i);
		`CHK("flush pulse", 1, n_flush)
		exp_q.delete();
		chk_fill(0);
		host.rd(gfr_pkg::ADDR_QPORT, rb);
		`CHK("flushed port", gfr_pkg::QEMPTY_BYTE, rb)
		host.wr(gfr_pkg::ADDR_QCFG1, 8'h00);
		`CHK("hdr off", 1'b0, hdr_en_o)
		// With headers off the header byte is dropped from the readout.
		push_frame();
		frame_evt(1'b0);
		repeat (8) @(posedge ref_clk_i);
		host.burst(gfr_pkg::ADDR_QPORT, 3, bb);
		for (int i = 1; i < 4; i++) `CHK("headerless", exp_q[i], bb[i-1])
		chk_fill(0);
		$display("test flush done");
		stop_test();
	end
endmodule
